//--- src/acs_defines.vh
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ---------------------------------------------------------------
// State structure layout (dword indices)
// ---------------------------------------------------------------
`define ACS_STATE_DWORDS      138
`define ACS_PHASES            17
`define ACS_DW_PER_PHASE      8
`define ACS_DW_CTRL_ADAPT     4
`define ACS_DW_BLEND          136
`define ACS_DW_BYPASS         137
`define ACS_DW_ADDR_W         8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACS_BIT_UV_ADAPT      15
`define ACS_BIT_RGB_LUMA      14
`define ACS_BLEND_HI          31
`define ACS_BLEND_LO          24
`define ACS_NBOUND_HI         23
`define ACS_NBOUND_LO         16
`define ACS_WBOUND_HI         15
`define ACS_WBOUND_LO         8
`define ACS_NTRANS_HI         6
`define ACS_NTRANS_LO         4
`define ACS_WTRANS_HI         2
`define ACS_WTRANS_LO         0
`define ACS_BIT_BYP_X         22
`define ACS_BIT_BYP_Y         21

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ACS_RST_DWORD         32'h00000000
`define ACS_RST_BYTE          8'h00

`endif

//--- src/acs_blend_sel.v
`include "acs_defines.vh"

module acs_blend_sel (
	input  wire       bypass_in,    // Direction bypass
	input  wire [7:0] fixed_in,     // Fixed blend weight
	input  wire [7:0] calc_in,      // Calculated weight
	output wire [7:0] weight_out    // Selected weight
);

	assign weight_out = bypass_in ? fixed_in : calc_in;

endmodule

//--- src/acs_scaler_state.v
// Function
// - Fetch coefficients and controls from memory via descriptor pointer per sample message.
// - Keep four tables: primary X, primary Y, secondary X, secondary Y.
// - Each table has 17 phases; primary 8 coefficients, secondary 4.
// - Coefficients are signed 8-bit S1.6 values.
// - Dword 4 bit 15 enables adaptive filtering on UV/RB channels.
// - Dword 4 bit 14 picks luma (R+2G+B)>>2, else green directly.
// - Dword 136 bits 31:24 fixed blend; 0 smooth, 255 sharp.
// - Dword 136 bits 23:16 and 15:8 are smooth area lower bounds.
// - Dword 136 bits 6:4 are four-pixel transition width.
// - Dword 136 bits 2:0 are eight-pixel transition width.
// - Dword 137 bit 22 bypasses horizontal adaptive, uses fixed blend.
// - Dword 137 bit 21 bypasses vertical adaptive, uses fixed blend.
`include "acs_defines.vh"

module acs_scaler_state #(
	parameter PTR_W = 32                       // Memory address width
) (
	input  wire              CLOCK_IN,         // Sampler clock
	input  wire              RST_IN,           // Async reset, active high
	input  wire              MSG_VALID_IN,     // Eight-tap sample message strobe
	input  wire [PTR_W-1:0]  STATE_PTR_IN,     // Descriptor state pointer
	output wire              MSG_READY_OUT,    // Idle, can take a message
	output reg               RD_REQ_OUT,       // Memory read request
	output reg  [PTR_W-1:0]  RD_ADDR_OUT,      // Byte address of dword
	input  wire              RD_VALID_IN,      // Read data valid
	input  wire [31:0]       RD_DATA_IN,       // Read data
	output reg               STATE_VALID_OUT,  // State loaded pulse
	input  wire [1:0]        TBL_SEL_IN,       // 0 X0,1 Y0,2 X1,3 Y1
	input  wire [4:0]        PHASE_IN,         // Phase 0..16
	input  wire [2:0]        TAP_IN,           // Coefficient index
	output reg  [7:0]        COEFF_OUT,        // S1.6 coefficient
	input  wire [7:0]        PIX_R_IN,         // Red
	input  wire [7:0]        PIX_G_IN,         // Green
	input  wire [7:0]        PIX_B_IN,         // Blue
	output reg  [7:0]        LUMA_OUT,         // Adaptive luma
	input  wire [7:0]        CALC_WX_IN,       // Calculated X weight
	input  wire [7:0]        CALC_WY_IN,       // Calculated Y weight
	output reg  [7:0]        WEIGHT_X_OUT,     // Applied X weight
	output reg  [7:0]        WEIGHT_Y_OUT,     // Applied Y weight
	output reg               UV_ADAPT_OUT,     // UV/RB adaptive enable
	output reg  [7:0]        NARROW_BOUND_OUT, // Four-pixel smooth bound
	output reg  [7:0]        WIDE_BOUND_OUT,   // Eight-pixel smooth bound
	output reg  [2:0]        NARROW_TRANS_OUT, // Four-pixel transition width
	output reg  [2:0]        WIDE_TRANS_OUT    // Eight-pixel transition width
);

	localparam ST_IDLE = 2'd0;
	localparam ST_REQ  = 2'd1;
	localparam ST_WAIT = 2'd2;

	localparam integer LAST_DW_INT = `ACS_STATE_DWORDS - 1;
	localparam [`ACS_DW_ADDR_W-1:0] LAST_DW = LAST_DW_INT[`ACS_DW_ADDR_W-1:0];

	// ---------------------------------------------------------------
	// State image
	// ---------------------------------------------------------------
	// Whole structure kept; tables are decoded out of it on lookup
	reg [31:0]               image_reg [0:`ACS_STATE_DWORDS-1];
	reg [1:0]                state_reg;
	reg [1:0]                state_next;
	reg [`ACS_DW_ADDR_W-1:0] dw_reg;
	reg [PTR_W-1:0]          base_reg;
	wire [7:0]               wx_sel;
	wire [7:0]               wy_sel;

	assign MSG_READY_OUT = (state_reg == ST_IDLE);

	// Dword index and byte lane of one coefficient
	function [10:0] coeff_loc;
		input [1:0] tbl;
		input [4:0] ph;
		input [2:0] tap;
		reg   [7:0] dw;
		begin
			dw = {ph[4:0], 3'b000};
			case (tbl)
				2'd0: dw = dw + {7'd0, tap[2]};
				2'd1: dw = dw + 8'd2 + {7'd0, tap[2]};
				2'd2: dw = dw + 8'd4 + {7'd0, tap[1]};
				default: dw = dw + 8'd6 + {7'd0, tap[1]};
			endcase
			// Secondary taps 0,1 sit in the upper half, taps 2,3 low in the next dword
			if (tbl[1])
				coeff_loc = {dw, ~tap[1], tap[0], 1'b0};
			else
				coeff_loc = {dw, tap[1:0], 1'b0};
		end
	endfunction

	// ---------------------------------------------------------------
	// Fetch sequencer
	// ---------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (MSG_VALID_IN) state_next = ST_REQ;
			ST_REQ:  state_next = ST_WAIT;
			ST_WAIT: begin
				if (RD_VALID_IN)
					state_next = (dw_reg == LAST_DW) ? ST_IDLE : ST_REQ;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_reg       <= ST_IDLE;
			dw_reg          <= {`ACS_DW_ADDR_W{1'b0}};
			base_reg        <= {PTR_W{1'b0}};
			RD_REQ_OUT      <= 1'b0;
			RD_ADDR_OUT     <= {PTR_W{1'b0}};
			STATE_VALID_OUT <= 1'b0;
		end else begin
			state_reg       <= state_next;
			RD_REQ_OUT      <= 1'b0;
			STATE_VALID_OUT <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (MSG_VALID_IN) begin
						base_reg <= STATE_PTR_IN;
						dw_reg   <= {`ACS_DW_ADDR_W{1'b0}};
					end
				end
				ST_REQ: begin
					RD_REQ_OUT  <= 1'b1;
					RD_ADDR_OUT <= base_reg + {{(PTR_W-`ACS_DW_ADDR_W-2){1'b0}}, dw_reg, 2'b00};
				end
				ST_WAIT: begin
					if (RD_VALID_IN) begin
						dw_reg <= dw_reg + 8'd1;
						if (dw_reg == LAST_DW)
							STATE_VALID_OUT <= 1'b1;
					end
				end
				default: dw_reg <= {`ACS_DW_ADDR_W{1'b0}};
			endcase
		end
	end

	// Image has no reset; validity is carried by STATE_VALID_OUT
	always @(posedge CLOCK_IN) begin
		if (state_reg == ST_WAIT && RD_VALID_IN)
			image_reg[dw_reg] <= RD_DATA_IN;
	end

	// ---------------------------------------------------------------
	// Coefficient lookup
	// ---------------------------------------------------------------
	// four tables
	// 17 phases, 8 or 4 taps
	wire [10:0] loc  = coeff_loc(TBL_SEL_IN, PHASE_IN, TAP_IN);
	wire [31:0] word = image_reg[loc[10:3]];
	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			COEFF_OUT <= `ACS_RST_BYTE;
		end else begin
			if (({27'd0, PHASE_IN} >= `ACS_PHASES) || (TBL_SEL_IN[1] && TAP_IN[2]))
				COEFF_OUT <= `ACS_RST_BYTE;
			else
				COEFF_OUT <= word[{loc[2:1], 3'b000} +: 8];
		end
	end

	// ---------------------------------------------------------------
	// Control decode and blend
	// ---------------------------------------------------------------
	wire [31:0] dw4   = image_reg[`ACS_DW_CTRL_ADAPT];
	wire [31:0] dw136 = image_reg[`ACS_DW_BLEND];
	wire [31:0] dw137 = image_reg[`ACS_DW_BYPASS];
	wire [9:0]  luma_sum = {2'b00, PIX_R_IN} + {1'b0, PIX_G_IN, 1'b0} + {2'b00, PIX_B_IN};

	acs_blend_sel u_blend_x (
		.bypass_in  (dw137[`ACS_BIT_BYP_X]),
		.fixed_in   (dw136[`ACS_BLEND_HI:`ACS_BLEND_LO]),
		.calc_in    (CALC_WX_IN),
		.weight_out (wx_sel)
	);

	acs_blend_sel u_blend_y (
		.bypass_in  (dw137[`ACS_BIT_BYP_Y]),
		.fixed_in   (dw136[`ACS_BLEND_HI:`ACS_BLEND_LO]),
		.calc_in    (CALC_WY_IN),
		.weight_out (wy_sel)
	);

	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			LUMA_OUT         <= `ACS_RST_BYTE;
			WEIGHT_X_OUT     <= `ACS_RST_BYTE;
			WEIGHT_Y_OUT     <= `ACS_RST_BYTE;
			UV_ADAPT_OUT     <= 1'b0;
			NARROW_BOUND_OUT <= `ACS_RST_BYTE;
			WIDE_BOUND_OUT   <= `ACS_RST_BYTE;
			NARROW_TRANS_OUT <= 3'd0;
			WIDE_TRANS_OUT   <= 3'd0;
		end else if (STATE_VALID_OUT || state_reg == ST_IDLE) begin
			LUMA_OUT <= dw4[`ACS_BIT_RGB_LUMA] ? luma_sum[9:2] : PIX_G_IN;
			WEIGHT_X_OUT <= wx_sel;
			WEIGHT_Y_OUT <= wy_sel;
			UV_ADAPT_OUT <= dw4[`ACS_BIT_UV_ADAPT];
			NARROW_BOUND_OUT <= dw136[`ACS_NBOUND_HI:`ACS_NBOUND_LO];
			WIDE_BOUND_OUT   <= dw136[`ACS_WBOUND_HI:`ACS_WBOUND_LO];
			NARROW_TRANS_OUT <= dw136[`ACS_NTRANS_HI:`ACS_NTRANS_LO];
			WIDE_TRANS_OUT   <= dw136[`ACS_WTRANS_HI:`ACS_WTRANS_LO];
		end
	end

endmodule

//--- sim/acs_state_properties.sv
module acs_state_properties #(
	parameter PTR_W = 32
) (
	input wire             CLOCK_IN,
	input wire             RST_IN,
	input wire             MSG_VALID_IN,
	input wire [PTR_W-1:0] STATE_PTR_IN,
	input wire             MSG_READY_OUT,
	input wire             RD_REQ_OUT,
	input wire [PTR_W-1:0] RD_ADDR_OUT,
	input wire             RD_VALID_IN,
	input wire [31:0]      RD_DATA_IN,
	input wire             STATE_VALID_OUT,
	input wire [7:0]       PIX_R_IN,
	input wire [7:0]       PIX_G_IN,
	input wire [7:0]       PIX_B_IN,
	input wire [7:0]       LUMA_OUT,
	input wire [7:0]       CALC_WX_IN,
	input wire [7:0]       CALC_WY_IN,
	input wire [7:0]       WEIGHT_X_OUT,
	input wire [7:0]       WEIGHT_Y_OUT,
	input wire [7:0]       NARROW_BOUND_OUT,
	input wire [7:0]       WIDE_BOUND_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PTR_W-1:0] base;
	logic [31:0]      d4, d136, d137;
	logic             ld;
	wire  [PTR_W-1:0] off = RD_ADDR_OUT - base;
	always @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			base <= '0;
			ld   <= 1'b0;
		end else begin
			if (MSG_VALID_IN && MSG_READY_OUT)
				base <= STATE_PTR_IN;
			if (STATE_VALID_OUT)
				ld <= 1'b1;
		end
	end
	// Shadow of the control dwords, not reset on purpose
	always @(posedge CLOCK_IN) begin
		if (RD_VALID_IN && !MSG_READY_OUT) begin
			if (off == 16) d4 <= RD_DATA_IN;
			if (off == 544) d136 <= RD_DATA_IN;
			if (off == 548) d137 <= RD_DATA_IN;
		end
	end
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_take; MSG_VALID_IN && MSG_READY_OUT; endsequence
	sequence s_first;
		!MSG_READY_OUT ##1 (RD_REQ_OUT && RD_ADDR_OUT == $past(STATE_PTR_IN, 2));
	endsequence
	sequence s_last; RD_VALID_IN && !MSG_READY_OUT && off == 548; endsequence
	// Three idle cycles so outputs reflect the new image
	sequence s_idle; (ld && MSG_READY_OUT) [*3]; endsequence
	AST_FIRST_READ: assert property (s_take |=> s_first)
		else $error("first read missing or wrong address");
	AST_NEXT_READ: assert property (RD_VALID_IN && !MSG_READY_OUT && off != 548 |->
		##1 !RD_REQ_OUT ##1 (RD_REQ_OUT && off == $past(off, 2) + 4))
		else $error("next dword read out of order");
	AST_LOAD_END: assert property (s_last |=>
		STATE_VALID_OUT && MSG_READY_OUT && !RD_REQ_OUT)
		else $error("load did not end after last dword");
	AST_BUSY: assert property (RD_REQ_OUT |-> !MSG_READY_OUT && !STATE_VALID_OUT)
		else $error("ready while loading");
	AST_LUMA: assert property (s_idle |->
		LUMA_OUT == (d4[14] ? ({2'b00, $past(PIX_R_IN)} + {1'b0, $past(PIX_G_IN), 1'b0}
		+ {2'b00, $past(PIX_B_IN)}) >> 2 : $past(PIX_G_IN)))
		else $error("luma wrong");
	AST_WEIGHT_X: assert property (s_idle |->
		WEIGHT_X_OUT == (d137[22] ? d136[31:24] : $past(CALC_WX_IN)))
		else $error("x weight wrong");
	AST_WEIGHT_Y: assert property (s_idle |->
		WEIGHT_Y_OUT == (d137[21] ? d136[31:24] : $past(CALC_WY_IN)))
		else $error("y weight wrong");
	AST_BOUNDS: assert property (s_idle |->
		NARROW_BOUND_OUT == d136[23:16] && WIDE_BOUND_OUT == d136[15:8])
		else $error("smooth bounds wrong");
endmodule

//--- sim/acs_mem_model.sv
module acs_mem_model (
	input  wire        clk_in,            // Clock
	input  wire        req_in,            // Read request
	input  wire [31:0] addr_in,           // Byte address
	input  wire [3:0]  lat_in,            // Latency, at least 1
	output reg         valid_out = 1'b0,  // Data valid
	output reg  [31:0] data_out = 32'h0   // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:255];
	logic [7:0]  idx;
	int          cnt = 0;
	always @(posedge clk_in) begin
		valid_out <= 1'b0;
		data_out  <= ~data_out;
		if (req_in) begin
			idx <= addr_in[9:2];
			cnt <= lat_in;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				valid_out <= 1'b1;
				data_out  <= mem[idx];
			end
		end
	end
endmodule

//--- sim/acs_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, mv = 1'b0, rdy, rq, rv, sv, uv;
	logic [31:0] ptr = 32'h1000, ra, rd;
	logic [1:0]  tbl = 2'h0;
	logic [4:0]  ph = 5'h00;
	logic [2:0]  tap = 3'h0, nt, wt;
	logic [3:0]  lat = 4'h1;
	logic [7:0]  pr = 8'hf0, pg = 8'h21, pb = 8'hff, cx = 8'h3c, cy = 8'hc3;
	logic [7:0]  coef, luma, wx, wy, nb, wb;
	int          n_errors = 0, total_checks = 0, cyc = 0;
	acs_scaler_state DUT (.CLOCK_IN(clk), .RST_IN(rst), .MSG_VALID_IN(mv), .STATE_PTR_IN(ptr),
		.MSG_READY_OUT(rdy), .RD_REQ_OUT(rq), .RD_ADDR_OUT(ra), .RD_VALID_IN(rv), .RD_DATA_IN(rd),
		.STATE_VALID_OUT(sv), .TBL_SEL_IN(tbl), .PHASE_IN(ph), .TAP_IN(tap), .COEFF_OUT(coef),
		.PIX_R_IN(pr), .PIX_G_IN(pg), .PIX_B_IN(pb), .LUMA_OUT(luma), .CALC_WX_IN(cx),
		.CALC_WY_IN(cy), .WEIGHT_X_OUT(wx), .WEIGHT_Y_OUT(wy), .UV_ADAPT_OUT(uv),
		.NARROW_BOUND_OUT(nb), .WIDE_BOUND_OUT(wb), .NARROW_TRANS_OUT(nt), .WIDE_TRANS_OUT(wt));
	acs_mem_model mm (.clk_in(clk), .req_in(rq), .addr_in(ra), .lat_in(lat),
		.valid_out(rv), .data_out(rd));
	initial forever #4 clk = ~clk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic scen(logic [15:0] ctl, logic [31:0] bl, logic [31:0] by, logic [3:0] l);
		int n;
		for (int i = 0; i < 138; i++)
			mm.mem[i] = {i[7:0] ^ 8'ha5, i[7:0] + 8'h40, i[7:0] ^ 8'h3c, i[7:0] + 8'h81};
		mm.mem[0][15:0] = 16'h0000;
		mm.mem[4][15:0] = ctl & 16'hc000;
		mm.mem[5][31:16] = 16'h0000;
		mm.mem[136] = bl & 32'hffff_ff77;
		mm.mem[137] = by & 32'h0060_0000;
		lat = l;
		mv = 1'b1;
		n = 0;
		for (int c = 0; c < 2000 && sv !== 1'b1; c++) begin
			@(negedge clk);
			mv = (c == 3);
			ptr = (c == 3) ? 32'h2000 : 32'h1000;
			if (rq === 1'b1) n++;
		end
		chk("reads", 138, n);
		chk("ready", 1, rdy);
		repeat (3) @(negedge clk);
		chk("luma", ctl[14] ? 8'h8c : pg, luma);
		chk("uv", ctl[15], uv);
		chk("narrow_bound", bl[23:16], nb);
		chk("wide_bound", bl[15:8], wb);
		chk("narrow_trans", bl[6:4], nt);
		chk("wide_trans", bl[2:0], wt);
		chk("weight_x", by[22] ? bl[31:24] : cx, wx);
		chk("weight_y", by[21] ? bl[31:24] : cy, wy);
		$display("load and decode test done");
	endtask
	task automatic coeffs();
		int d;
		int b;
		for (int t = 0; t < 4; t++)
			for (int p = 0; p < 18; p++)
				for (int k = 0; k < 8; k++) begin
					tbl = t[1:0];
					ph = p[4:0];
					tap = k[2:0];
					@(negedge clk);
					d = (t < 2) ? 8 * p + k / 4 + 2 * t : 8 * p + 4 + 2 * (t - 2) + k / 2;
					b = (t < 2) ? k % 4 : k % 2 + 2 * (1 - k / 2);
					if (p > 16 || (t > 1 && k > 3)) chk("coeff", 0, coef);
					else chk("coeff", mm.mem[d][8 * b +: 8], coef);
				end
		$display("coefficient test done");
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		scen(16'hc000, 32'hc87e_1953, 32'h0040_0000, 4'h1);
		coeffs();
		scen(16'h0000, 32'hff00_ff70, 32'h0020_0000, 4'h5);
		summarize();
	end
endmodule
bind acs_scaler_state acs_state_properties #(.PTR_W(PTR_W)) u_props (
	.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .MSG_VALID_IN(MSG_VALID_IN),
	.STATE_PTR_IN(STATE_PTR_IN), .MSG_READY_OUT(MSG_READY_OUT), .RD_REQ_OUT(RD_REQ_OUT),
	.RD_ADDR_OUT(RD_ADDR_OUT), .RD_VALID_IN(RD_VALID_IN), .RD_DATA_IN(RD_DATA_IN),
	.STATE_VALID_OUT(STATE_VALID_OUT), .PIX_R_IN(PIX_R_IN), .PIX_G_IN(PIX_G_IN),
	.PIX_B_IN(PIX_B_IN), .LUMA_OUT(LUMA_OUT), .CALC_WX_IN(CALC_WX_IN), .CALC_WY_IN(CALC_WY_IN),
	.WEIGHT_X_OUT(WEIGHT_X_OUT), .WEIGHT_Y_OUT(WEIGHT_Y_OUT),
	.NARROW_BOUND_OUT(NARROW_BOUND_OUT), .WIDE_BOUND_OUT(WIDE_BOUND_OUT));
